// ===== design/qt_pkg.sv
// types shared by the timer block
package qt_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    KIND_STOP  = 4'b0001,
    KIND_DELAY = 4'b0010,
    KIND_EVENT = 4'b0100,
    KIND_PULSE = 4'b1000
  } timer_kind_t;
endpackage

// ===== design/quad_prescaled_timers.sv
// four prescaled down-counter timers with their host byte registers
`timescale 1ns/1ps
`default_nettype none
`include "quad_timers_map.svh"
module quad_prescaled_timers (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       chipSelN,
  input  wire logic       busStrobeN,
  input  wire logic       readNotWrite,
  input  wire logic [4:0] regAddr,
  input  wire logic [7:0] dataIn,
  output var  logic [7:0] dataOut,
  output var  logic       dataOe,
  input  wire logic       timerAAuxInput,
  input  wire logic       timerBAuxInput,
  input  wire logic       edgeSelA,
  input  wire logic       edgeSelB,
  output var  logic [3:0] timerOut,
  output var  logic [3:0] timeoutPulse,
  output var  logic       gpLineFourLevel,
  output var  logic       gpLineThreeLevel
);
  logic [3:0]    modeA_q;
  logic [3:0]    modeB_q;
  logic [2:0]    modeC_q;
  logic [2:0]    modeD_q;
  logic [3:0]    modeArr [4];
  logic [3:0]    forceLow;
  logic [3:0]    dataWr;
  logic          strobePrev_q;
  logic          selected;
  logic          accStart;
  logic          wrStart;
  logic          rdStart;
  logic          strobeRise;
  qt_pkg::byte_t rdMux;
  qt_pkg::byte_t dataOut_q;
  qt_pkg::byte_t reload_q [4];
  qt_pkg::byte_t count_q [4];
  qt_pkg::byte_t readReg_q [4];
  logic [3:0]    outLvl_q;
  logic [3:0]    timeout_q;
  logic [3:0]    auxArr;
  logic [3:0]    edgeArr;
  logic          gpFour_q;
  logic          gpThree_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // host bus: strobe edges taken from the synchronous pin
  assign selected   = !chipSelN && !busStrobeN;
  assign accStart   = !chipSelN && !busStrobeN && strobePrev_q;
  assign wrStart    = accStart && !readNotWrite;
  assign rdStart    = accStart && readNotWrite;
  assign strobeRise = busStrobeN && !strobePrev_q;
  assign dataOe     = selected && readNotWrite;
  assign dataOut    = dataOut_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      strobePrev_q <= 1'b1;
    else
      strobePrev_q <= busStrobeN;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeA_q <= `QT_CTRL_RESET;
      modeB_q <= `QT_CTRL_RESET;
      modeC_q <= `QT_CD_RESET;
      modeD_q <= `QT_CD_RESET;
    end else if (wrStart) begin
      case (regAddr)
        `QT_REG_CTRL_A: modeA_q <= dataIn[3:0];
        `QT_REG_CTRL_B: modeB_q <= dataIn[3:0];
        `QT_REG_CTRL_CD: begin
          modeC_q <= dataIn[`QT_CD_C_LSB +: 3];
          modeD_q <= dataIn[`QT_CD_D_LSB +: 3];
        end
        default: ;
      endcase
    end
  end

  // C and D see only stop or delay codes
  assign modeArr[0] = modeA_q;
  assign modeArr[1] = modeB_q;
  assign modeArr[2] = {1'b0, modeC_q};
  assign modeArr[3] = {1'b0, modeD_q};
  assign auxArr     = {2'b00, timerBAuxInput, timerAAuxInput};
  assign edgeArr    = {2'b00, edgeSelB, edgeSelA};

  // held for the whole write cycle, not just its first clock
  assign forceLow[0] = selected && !readNotWrite &&
                       (regAddr == `QT_REG_CTRL_A) &&
                       dataIn[`QT_OUT_RESET_BIT];
  assign forceLow[1] = selected && !readNotWrite &&
                       (regAddr == `QT_REG_CTRL_B) &&
                       dataIn[`QT_OUT_RESET_BIT];
  assign forceLow[3:2] = 2'b00;

  always_comb begin
    case (regAddr)
      `QT_REG_CTRL_A:  rdMux = {4'h0, modeA_q};
      `QT_REG_CTRL_B:  rdMux = {4'h0, modeB_q};
      `QT_REG_CTRL_CD: rdMux = {1'b0, modeC_q, 1'b0, modeD_q};
      `QT_REG_DATA_BASE:        rdMux = readReg_q[0];
      `QT_REG_DATA_BASE + 5'h1: rdMux = readReg_q[1];
      `QT_REG_DATA_BASE + 5'h2: rdMux = readReg_q[2];
      `QT_REG_DATA_BASE + 5'h3: rdMux = readReg_q[3];
      default:         rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      dataOut_q <= 8'h00;
    else if (rdStart)
      dataOut_q <= rdMux;
  end

  // pulse width mode inverts the level seen by the aux interrupt
  // channel, so its active edge becomes the end of the pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gpFour_q  <= 1'b0;
      gpThree_q <= 1'b0;
    end else begin
      gpFour_q  <= timerAAuxInput ^
                   (modeA_q[3] && (modeA_q != `QT_MODE_EVENT));
      gpThree_q <= timerBAuxInput ^
                   (modeB_q[3] && (modeB_q != `QT_MODE_EVENT));
    end
  end
  assign gpLineFourLevel  = gpFour_q;
  assign gpLineThreeLevel = gpThree_q;
  assign timerOut         = outLvl_q;
  assign timeoutPulse     = timeout_q;

  tick_if tif [4] ();

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_timer
      logic stopped;
      logic tick;
      logic wrap;

      assign tif[g].mode    = modeArr[g];
      assign tif[g].aux     = auxArr[g];
      assign tif[g].edgeSel = edgeArr[g];

      timer_tick_source u_src (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (tif[g])
      );

      assign stopped   = (modeArr[g] == `QT_MODE_STOP);
      assign tick      = tif[g].countPulse;
      assign wrap      = tick && (count_q[g] == `QT_CNT_ONE);
      assign dataWr[g] = wrStart &&
                         (regAddr == `QT_REG_DATA_BASE + 5'(g));

      // counter and reload survive reset on purpose
      always_ff @(posedge core_clk) begin
        if (dataWr[g])
          reload_q[g] <= dataIn;
      end

      always_ff @(posedge core_clk) begin
        if (dataWr[g] && stopped)
          count_q[g] <= dataIn;
        else if (wrap)
          count_q[g] <= reload_q[g];
        else if (tick)
          count_q[g] <= count_q[g] - `QT_CNT_ONE;
      end

      always_ff @(posedge core_clk) begin
        if (strobeRise)
          readReg_q[g] <= count_q[g];
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
          timeout_q[g] <= 1'b0;
        else
          timeout_q[g] <= wrap;
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
          outLvl_q[g] <= 1'b0;
        else if (forceLow[g])
          outLvl_q[g] <= 1'b0;
        else if (wrap)
          outLvl_q[g] <= !outLvl_q[g];
      end

      property p_stop_hold;
        stopped && !dataWr[g] && !tick |=> $stable(count_q[g]);
      endproperty
      a_stop_hold: assert property (p_stop_hold)
        else $error("stopped timer changed its count");

      property p_reload;
        wrap && !dataWr[g] |=> count_q[g] == $past(reload_q[g]) &&
                              timeout_q[g];
      endproperty
      a_reload: assert property (p_reload)
        else $error("count of one did not reload with time-out");

      property p_decrement;
        tick && (count_q[g] != `QT_CNT_ONE) && !dataWr[g]
          |=> count_q[g] == $past(count_q[g]) - `QT_CNT_ONE &&
              !timeout_q[g];
      endproperty
      a_decrement: assert property (p_decrement)
        else $error("count pulse did not decrement by one");

      property p_toggle;
        wrap && !forceLow[g] |=> outLvl_q[g] != $past(outLvl_q[g]);
      endproperty
      a_toggle: assert property (p_toggle)
        else $error("time-out did not toggle the output");

      property p_force_low;
        forceLow[g] |=> !outLvl_q[g];
      endproperty
      a_force_low: assert property (p_force_low)
        else $error("output reset write left output high");

      property p_stop_load;
        dataWr[g] && stopped |=> count_q[g] == $past(dataIn) &&
                                 reload_q[g] == $past(dataIn);
      endproperty
      a_stop_load: assert property (p_stop_load)
        else $error("write to stopped timer did not load counter");

      property p_capture;
        strobeRise |=> readReg_q[g] == $past(count_q[g]);
      endproperty
      a_capture: assert property (p_capture)
        else $error("read register missed strobe rise capture");

      property p_timeout_single;
        timeout_q[g] |=> !timeout_q[g];
      endproperty
      a_timeout_single: assert property (p_timeout_single)
        else $error("time-out pulse lasted more than one cycle");
    end
  endgenerate

  property p_ctrl_unused;
    rdStart && (regAddr == `QT_REG_CTRL_A) |=> dataOut[7:4] == 4'h0;
  endproperty
  a_ctrl_unused: assert property (p_ctrl_unused)
    else $error("unused control bits did not read as zero");

  // with the edge bit set, the end of a measured pulse must show as a rising channel level
  property p_pulse_end_a;
    $stable(modeA_q) && modeA_q[3] && (modeA_q != `QT_MODE_EVENT) &&
      $fell(timerAAuxInput) |=> $rose(gpFour_q);
  endproperty
  a_pulse_end_a: assert property (p_pulse_end_a)
    else $error("timer A pulse end gave no channel edge");

  property p_pulse_end_b;
    $stable(modeB_q) && modeB_q[3] && (modeB_q != `QT_MODE_EVENT) &&
      $fell(timerBAuxInput) |=> $rose(gpThree_q);
  endproperty
  a_pulse_end_b: assert property (p_pulse_end_b)
    else $error("timer B pulse end gave no channel edge");

  c_timeout_a: cover property (timeout_q[0] ##[1:300] timeout_q[0]);
  c_force_low: cover property (forceLow[0] && outLvl_q[0]);
  c_event_b:   cover property ((modeB_q == `QT_MODE_EVENT) && timeout_q[1]);
  c_pulse_a:   cover property (modeA_q[3] && $fell(gpFour_q));
endmodule // quad_prescaled_timers
`default_nettype wire

// ===== design/quad_timers_map.svh
// register map, field positions and timing constants of the four timers
`ifndef QUAD_TIMERS_MAP_SVH
`define QUAD_TIMERS_MAP_SVH

`define QT_REG_CTRL_A    5'h0c
`define QT_REG_CTRL_B    5'h0d
`define QT_REG_CTRL_CD   5'h0e
`define QT_REG_DATA_BASE 5'h0f

`define QT_OUT_RESET_BIT 4
`define QT_CD_C_LSB      4
`define QT_CD_D_LSB      0

`define QT_MODE_STOP     4'h0
`define QT_MODE_EVENT    4'h8
`define QT_CNT_ONE       8'h01
`define QT_CTRL_RESET    4'h0
`define QT_CD_RESET      3'h0
`define QT_PRE_RESET     8'h00

`define QT_PRE_4         8'h04
`define QT_PRE_10        8'h0a
`define QT_PRE_16        8'h10
`define QT_PRE_50        8'h32
`define QT_PRE_64        8'h40
`define QT_PRE_100       8'h64
`define QT_PRE_200       8'hc8

`endif

// ===== design/tick_if.sv
// carrier between a timer counter and its count pulse source
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic [3:0] mode;
  logic       aux;
  logic       edgeSel;
  logic       countPulse;
  modport src  (input mode, input aux, input edgeSel, output countPulse);
  modport user (output mode, output aux, output edgeSel, input countPulse);
endinterface // tick_if
`default_nettype wire

// ===== design/timer_tick_source.sv
// prescaler and auxiliary input logic that makes one timer's count pulses
`timescale 1ns/1ps
`default_nettype none
`include "quad_timers_map.svh"
module timer_tick_source (
  input wire logic core_clk,
  input wire logic rst,
  tick_if.src      tif
);
  qt_pkg::timer_kind_t kind;
  qt_pkg::byte_t       pre_q;
  qt_pkg::byte_t       divisor;
  logic                active;
  logic                prevActive_q;
  logic                preRun;
  logic                preTick;
  logic                evtPulse;
  logic                countPulse_q;

  always_comb begin
    if (tif.mode == `QT_MODE_STOP)
      kind = qt_pkg::KIND_STOP;
    else if (tif.mode == `QT_MODE_EVENT)
      kind = qt_pkg::KIND_EVENT;
    else if (tif.mode[3])
      kind = qt_pkg::KIND_PULSE;
    else
      kind = qt_pkg::KIND_DELAY;
  end

  // pulse width codes share the delay ratios through the low three bits
  always_comb begin
    case (tif.mode[2:0])
      3'h1:    divisor = `QT_PRE_4;
      3'h2:    divisor = `QT_PRE_10;
      3'h3:    divisor = `QT_PRE_16;
      3'h4:    divisor = `QT_PRE_50;
      3'h5:    divisor = `QT_PRE_64;
      3'h6:    divisor = `QT_PRE_100;
      3'h7:    divisor = `QT_PRE_200;
      default: divisor = `QT_PRE_4;
    endcase
  end

  assign active = tif.aux ~^ tif.edgeSel;
  assign preRun = (kind == qt_pkg::KIND_DELAY) ||
                  ((kind == qt_pkg::KIND_PULSE) && active);
  // a residue beyond a new, smaller ratio ticks at once, so a prescale
  // change only disturbs the first interval
  assign preTick = preRun && (pre_q >= divisor - `QT_CNT_ONE);
  // an edge bit change flips the active level and can count as well
  assign evtPulse = (kind == qt_pkg::KIND_EVENT) && active &&
                    !prevActive_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      pre_q <= `QT_PRE_RESET;
    else if (!preRun)
      pre_q <= `QT_PRE_RESET;
    else if (preTick)
      pre_q <= `QT_PRE_RESET;
    else
      pre_q <= pre_q + `QT_CNT_ONE;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      prevActive_q <= 1'b0;
    else
      prevActive_q <= active;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      countPulse_q <= 1'b0;
    else
      countPulse_q <= preTick || evtPulse;
  end

  assign tif.countPulse = countPulse_q;

  property p_no_back_to_back;
    @(posedge core_clk) disable iff (rst)
    countPulse_q |=> !countPulse_q;
  endproperty
  a_no_back_to_back: assert property (p_no_back_to_back)
    else $error("count pulses came on adjacent cycles");

  property p_event_counts;
    @(posedge core_clk) disable iff (rst)
    (kind == qt_pkg::KIND_EVENT) && active && !prevActive_q
      |=> countPulse_q;
  endproperty
  a_event_counts: assert property (p_event_counts)
    else $error("active edge in event mode gave no count pulse");

  property p_pulse_gate;
    @(posedge core_clk) disable iff (rst)
    (kind == qt_pkg::KIND_PULSE) && !active |=> !countPulse_q;
  endproperty
  a_pulse_gate: assert property (p_pulse_gate)
    else $error("pulse width timer counted while input inactive");

  property p_div4;
    @(posedge core_clk) disable iff (rst)
    (tif.mode == 4'h1)[*8] ##0 countPulse_q |-> $past(countPulse_q, 4);
  endproperty
  a_div4: assert property (p_div4)
    else $error("prescale by four gave wrong pulse spacing");
endmodule // timer_tick_source
`default_nettype wire

// ===== dv/host_model.sv
// host bus and auxiliary input model facing the timer block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       core_clk,
  output var  logic       chipSelN,
  output var  logic       busStrobeN,
  output var  logic       readNotWrite,
  output var  logic [4:0] regAddr,
  output var  logic [7:0] dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  output var  logic [1:0] aux
);
  initial begin
    chipSelN = 1'b1;
    busStrobeN = 1'b1;
    readNotWrite = 1'b1;
    regAddr = 5'h00;
    dataIn = 8'h00;
    aux = 2'b00;
  end

  // one strobe-low period per access; idle edges after it let the
  // read register refresh before anything else moves
  task automatic access(input logic rnw, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic oe);
    @(posedge core_clk);
    chipSelN <= 1'b0;
    busStrobeN <= 1'b0;
    readNotWrite <= rnw;
    regAddr <= a;
    dataIn <= d;
    repeat (3) @(posedge core_clk);
    q = dataOut;
    oe = dataOe;
    chipSelN <= 1'b1;
    busStrobeN <= 1'b1;
    readNotWrite <= 1'b1;
    regAddr <= ~a;
    dataIn <= ~d;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic setAux(input int i, input logic v);
    @(posedge core_clk);
    aux[i] <= v;
  endtask

  // each level held n >= 4 timer clocks so no transition is lost
  task automatic auxPulse(input int i, input int n);
    @(posedge core_clk);
    aux[i] <= ~aux[i];
    repeat (n) @(posedge core_clk);
    aux[i] <= ~aux[i];
    repeat (n) @(posedge core_clk);
  endtask
endmodule // host_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the four prescaled timers
`timescale 1ns/1ps
`default_nettype none
`include "quad_timers_map.svh"
module tb;
  logic       core_clk;
  logic       rst;
  logic       chipSelN, busStrobeN, readNotWrite;
  logic [4:0] regAddr;
  logic [7:0] dataIn, dataOut, q;
  logic       dataOe, oe, edgeA, edgeB, gp4, gp3, mOut;
  logic [1:0] aux;
  logic [3:0] timerOut, timeoutPulse;
  logic [7:0] v [4];
  int         failures, nCompared, mCnt, mRel, mCap, mTo, n;
  int         toCnt [4];
  int         ratio [$] = '{4, 10, 16, 50, 64, 100, 200};

  quad_prescaled_timers quad_prescaled_timers_i (
    .core_clk(core_clk), .rst(rst), .chipSelN(chipSelN),
    .busStrobeN(busStrobeN), .readNotWrite(readNotWrite),
    .regAddr(regAddr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .timerAAuxInput(aux[0]), .timerBAuxInput(aux[1]),
    .edgeSelA(edgeA), .edgeSelB(edgeB), .timerOut(timerOut),
    .timeoutPulse(timeoutPulse), .gpLineFourLevel(gp4),
    .gpLineThreeLevel(gp3));
  host_model host_model_i (
    .core_clk(core_clk), .chipSelN(chipSelN), .busStrobeN(busStrobeN),
    .readNotWrite(readNotWrite), .regAddr(regAddr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .aux(aux));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (timeoutPulse[i] === 1'b1) toCnt[i]++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time,
               what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, failed %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // the read register keeps what the previous strobe rise captured
  task automatic acc(input logic rnw, input logic [4:0] a,
                     input logic [7:0] d);
    host_model_i.access(rnw, a, d, q, oe);
    mCap = mCnt;
  endtask

  task automatic rdA();
    logic [7:0] e;
    e = 8'(mCap);
    acc(1'b1, `QT_REG_DATA_BASE, 8'h00);
    check(q, e, "read A");
  endtask

  task automatic waitTo(input int i, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (timeoutPulse[i] !== 1'b1 && c < 2100);
  endtask

  // first time-out after a change may be off, so time the second one
  task automatic interval(input int i, input int exp);
    int   c;
    logic o;
    waitTo(i, c);
    // expected level is taken one bit wide so it is not widened first
    o = !timerOut[i];
    waitTo(i, c);
    check(16'(c), 16'(exp), "interval");
    check(timerOut[i], o, "toggle");
  endtask

  task automatic evt();
    host_model_i.auxPulse(0, 4 + ($urandom % 4));
    if (mCnt == 1) begin
      mCnt = mRel;
      mTo++;
      mOut = ~mOut;
    end else begin
      mCnt = (mCnt + 255) % 256;
    end
    check(16'(toCnt[0]), 16'(mTo), "event time-outs");
    check(timerOut[0], mOut, "event output");
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog ran out", $time);
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    edgeA = 1'b1;
    edgeB = 1'b1;
    failures = 0;
    nCompared = 0;
    mCnt = 0;
    mRel = 0;
    mOut = 1'b0;
    n = $urandom(32'h6d99);
    repeat (5) @(posedge core_clk);
    check(16'(timerOut), 16'h0000, "outputs in reset");
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      v[i] = 8'($urandom);
      acc(1'b0, `QT_REG_DATA_BASE + 5'(i), v[i]);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `QT_REG_DATA_BASE + 5'(i), 8'h00);
      check(q, v[i], "stopped load");
      check(oe, 1'b1, "read enable");
    end
    acc(1'b0, `QT_REG_CTRL_A, 8'he7);
    acc(1'b1, `QT_REG_CTRL_A, 8'h00);
    check(q, 8'h07, "ctrl A unused bits");
    acc(1'b0, `QT_REG_CTRL_CD, 8'hff);
    acc(1'b1, `QT_REG_CTRL_CD, 8'h00);
    check(q, 8'h77, "ctrl CD unused bits");
    acc(1'b0, `QT_REG_CTRL_CD, 8'h00);
    acc(1'b1, 5'h1f, 8'h00);
    check(q, 8'h00, "unmapped read");
    $display("test registers done");
    acc(1'b0, `QT_REG_CTRL_A, 8'h00);
    acc(1'b0, `QT_REG_DATA_BASE, 8'h02);
    // codes change without a stop in between
    for (int k = 1; k < 8; k++) begin
      acc(1'b0, `QT_REG_CTRL_A, 8'(k));
      interval(0, 2 * ratio[k - 1]);
    end
    acc(1'b0, `QT_REG_CTRL_A, 8'h00);
    $display("test delay codes done");
    acc(1'b0, `QT_REG_DATA_BASE + 5'd1, 8'h02);
    host_model_i.setAux(1, 1'b1);
    for (int k = 9; k < 16; k++) begin
      acc(1'b0, `QT_REG_CTRL_B, 8'(k));
      interval(1, 2 * ratio[k - 9]);
    end
    check(gp3, 1'b0, "pulse channel level");
    host_model_i.setAux(1, 1'b0);
    n = toCnt[1];
    repeat (600) @(posedge core_clk);
    check(16'(toCnt[1]), 16'(n), "gate closed");
    check(gp3, 1'b1, "pulse end level");
    edgeB <= 1'b0;
    interval(1, 400);
    acc(1'b0, `QT_REG_CTRL_B, 8'h00);
    check(gp3, 1'b0, "leaving pulse mode");
    $display("test pulse width done");
    acc(1'b0, `QT_REG_DATA_BASE + 5'd2, 8'h03);
    acc(1'b0, `QT_REG_DATA_BASE + 5'd3, 8'h00);
    acc(1'b0, `QT_REG_CTRL_CD, 8'h11);
    interval(2, 12);
    interval(3, 1024);
    acc(1'b0, `QT_REG_CTRL_CD, 8'h00);
    $display("test C and D done");
    acc(1'b0, `QT_REG_CTRL_A, 8'h00);
    mCnt = 10;
    mRel = 10;
    acc(1'b0, `QT_REG_DATA_BASE, 8'h0a);
    acc(1'b0, `QT_REG_CTRL_A, 8'h08);
    mTo = toCnt[0];
    mOut = timerOut[0];
    repeat (3) evt();
    rdA();
    rdA();
    // count is 7 here, well away from the unsafe 01
    mRel = 2;
    acc(1'b0, `QT_REG_DATA_BASE, 8'h02);
    rdA();
    fork
      acc(1'b0, `QT_REG_CTRL_A, 8'h18);
      begin
        repeat (3) @(posedge core_clk);
        check(timerOut[0], 1'b0, "forced low");
      end
    join
    mOut = 1'b0;
    repeat (8) evt();
    check(gp4, aux[0], "aux A channel level");
    acc(1'b0, `QT_REG_CTRL_A, 8'h00);
    repeat (50) @(posedge core_clk);
    rdA();
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(16'(timerOut), 16'h0000, "outputs in reset");
    rst <= 1'b0;
    rdA();
    rdA();
    $display("test event count done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
